//--- rtl/ptmr_pkg.sv
// Shared constants of the period timer: register map, field layout,
// reset values and scaler limits.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
package ptmr_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CNT_W = 8;             // Timer and period width
  localparam int SCL_W = 4;             // Prescaler and postscaler width
  localparam int ADR_W = 5;             // Byte address bits decoded
  localparam int INS_DIV = 4;           // Instruction clock = MCLK / 4

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_COUNT = 5'h00;   // timer_count
  localparam logic [4:0] OFS_PERIOD = 5'h04;  // period_value
  localparam logic [4:0] OFS_CTRL = 5'h08;    // timer_control
  localparam logic [4:0] OFS_FLAG = 5'h0C;    // peripheral_flag_reg
  localparam logic [4:0] OFS_ENABLE = 5'h10;  // peripheral_enable_reg

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PRE_LSB = 0;           // prescale_select [1:0]
  localparam int POST_LSB = 3;          // postscale_select [6:3]
  localparam int FLAG_BIT = 0;          // match_irq_flag
  localparam int ENABLE_BIT = 0;        // match_irq_enable

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  localparam logic [1:0] PRE_RST = 2'h0;
  localparam logic [3:0] POST_RST = 4'h0;

  // ----------------------------------------------------------------
  // Prescaler terminal counts
  // ----------------------------------------------------------------
  localparam logic [3:0] PRE_LIM_1 = 4'h0;    // Divide by one
  localparam logic [3:0] PRE_LIM_4 = 4'h3;    // Divide by four
  localparam logic [3:0] PRE_LIM_16 = 4'hF;   // Divide by sixteen
  localparam logic [1:0] PRE_CODE_1 = 2'h0;
  localparam logic [1:0] PRE_CODE_4 = 2'h1;

endpackage

//--- rtl/inst_clk_div.sv
// Instruction clock divider: one-cycle enable every DIV clocks.
// Assumes a single free-running clock and an asynchronous low reset.
`timescale 1ns/100ps
module inst_clk_div
#(
  parameter int DIV = 4
)
(
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);

  // Phase counter within one instruction cycle
  logic [$clog2(DIV)-1:0] phase;
  // Last phase reached
  wire last_phase = (phase == ($clog2(DIV))'(DIV - 1));

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // Count phases and pulse on the wrap
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase <= '0;
      tick <= 1'b0;
    end
    else
    begin
      phase <= last_phase ? '0 : phase + 1'b1;
      tick <= last_phase;
    end
  end

endmodule // inst_clk_div

//--- rtl/scale_counter.sv
// Ratio counter used as prescaler and postscaler: wraps on limit.
// Assumes step and clear come from logic on the same clock.
`timescale 1ns/100ps
module scale_counter
#(
  parameter int W = 4
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic step,
  input wire logic [W-1:0] limit,
  output logic wrap
);

  // Current count
  logic [W-1:0] count;
  // Count reaches its limit on this step
  assign wrap = step && !clear && (count >= limit);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Clear wins; otherwise step and wrap
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= '0;
    else if (clear)
      count <= '0;
    else if (wrap)
      count <= '0;
    else if (step)
      count <= count + 1'b1;
  end

endmodule // scale_counter

//--- rtl/period_timer.sv
// Period timer with prescaler, postscaler and match interrupt,
// reached over a classic Wishbone slave port.
// Assumes one clock MCLK at 125 MHz and an asynchronous low reset
// that stands for every device reset source.
`timescale 1ns/100ps

// Overview of operation
// - Counts on the MCLK/4 instruction tick
// - Counter counts up from zero
// - Prescaler divides by one, four or sixteen
// - Counter equal to period gives match pulse
// - Match clears counter, steps postscaler
// - Counter and period are software readable, writable
// - Reset clears counter, period becomes all ones
// - Writes to counter or control clear scalers
// - Postscaler terminal count sets the flag
// - Interrupt only when flag and enable set
// - Sixteen postscale ratios, one to sixteen
// - Match pulse synchronous to the system clock
// - Sleep stops counting, holds counter and period
module period_timer
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic SLEEP,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ptmr_pkg::ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic PERIOD_MATCH,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [ptmr_pkg::CNT_W-1:0] timer_count;   // Running count
  logic [ptmr_pkg::CNT_W-1:0] period_value;  // Match value
  logic [1:0] prescale_select;               // Prescale code
  logic [3:0] postscale_select;              // Postscale ratio minus one
  logic match_irq_flag;                      // Sticky interrupt flag
  logic match_irq_enable;                    // Interrupt mask
  logic sleep_s1, sleep_s2, sleep_s3;        // Sleep synchroniser
  logic sleep_state;                         // Filtered sleep level

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire req = WB_CYC_I && WB_STB_I && !WB_ACK_O;     // New access
  wire wr = req && WB_WE_I && WB_SEL_I[0];           // Low lane write
  wire rd = req && !WB_WE_I;                          // Read access
  wire hit_count = (WB_ADR_I == ptmr_pkg::OFS_COUNT);
  wire hit_period = (WB_ADR_I == ptmr_pkg::OFS_PERIOD);
  wire hit_ctrl = (WB_ADR_I == ptmr_pkg::OFS_CTRL);
  wire hit_flag = (WB_ADR_I == ptmr_pkg::OFS_FLAG);
  wire hit_enable = (WB_ADR_I == ptmr_pkg::OFS_ENABLE);
  wire wr_count = wr && hit_count;
  wire wr_period = wr && hit_period;
  wire wr_ctrl = wr && hit_ctrl;
  wire wr_flag = wr && hit_flag;
  wire wr_enable = wr && hit_enable;
  wire rd_flag = rd && hit_flag;
  wire [7:0] wdat = WB_DAT_I[7:0];

  // Read multiplexer, unmapped addresses read zero
  wire [7:0] ctrl_view = {1'b0, postscale_select, 1'b0, prescale_select};
  wire [7:0] rd_byte =
    hit_count ? timer_count :
    hit_period ? period_value :
    hit_ctrl ? ctrl_view :
    hit_flag ? {7'h00, match_irq_flag} :
    hit_enable ? {7'h00, match_irq_enable} : 8'h00;

  // ----------------------------------------------------------------
  // Timing chain
  // ----------------------------------------------------------------
  logic ins_tick;       // Instruction clock enable
  logic pre_wrap;       // Prescaled count enable
  logic post_wrap;      // Postscaler terminal count

  wire scaler_clear = wr_count || wr_ctrl;
  wire pre_step = ins_tick && !sleep_state;
  wire at_period = (timer_count == period_value);
  wire count_step = pre_wrap && !wr_count;           // Write wins
  wire match_now = count_step && at_period;

  // Prescale code to terminal count
  wire [3:0] pre_limit =
    (prescale_select == ptmr_pkg::PRE_CODE_1) ? ptmr_pkg::PRE_LIM_1 :
    (prescale_select == ptmr_pkg::PRE_CODE_4) ? ptmr_pkg::PRE_LIM_4 :
    ptmr_pkg::PRE_LIM_16;

  // Instruction clock from the system clock
  inst_clk_div #(.DIV(ptmr_pkg::INS_DIV)) u_div
  (
    .clk(MCLK),
    .rst_n(RST_N),
    .tick(ins_tick)
  );

  // Prescaler ahead of the counter
  scale_counter #(.W(ptmr_pkg::SCL_W)) u_pre
  (
    .clk(MCLK),
    .rst_n(RST_N),
    .clear(scaler_clear),
    .step(pre_step),
    .limit(pre_limit),
    .wrap(pre_wrap)
  );

  // Postscaler stepped by match events
  scale_counter #(.W(ptmr_pkg::SCL_W)) u_post
  (
    .clk(MCLK),
    .rst_n(RST_N),
    .clear(scaler_clear),
    .step(match_now),
    .limit(postscale_select),
    .wrap(post_wrap)
  );

  // ----------------------------------------------------------------
  // Sleep synchroniser
  // ----------------------------------------------------------------
  // Three stages; level accepted when the last two agree
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sleep_s1 <= 1'b0;
      sleep_s2 <= 1'b0;
      sleep_s3 <= 1'b0;
      sleep_state <= 1'b0;
    end
    else
    begin
      sleep_s1 <= SLEEP;
      sleep_s2 <= sleep_s1;
      sleep_s3 <= sleep_s2;
      if (sleep_s2 == sleep_s3)
        sleep_state <= sleep_s3;
    end
  end

  // ----------------------------------------------------------------
  // Counter and period
  // ----------------------------------------------------------------
  // Software write first, then match clear, then increment
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      timer_count <= ptmr_pkg::COUNT_RST;
      period_value <= ptmr_pkg::PERIOD_RST;
    end
    else
    begin
      if (wr_count)
        timer_count <= wdat;
      else if (match_now)
        timer_count <= ptmr_pkg::COUNT_RST;
      else if (count_step)
        timer_count <= timer_count + 1'b1;
      if (wr_period)
        period_value <= wdat;
    end
  end

  // ----------------------------------------------------------------
  // Control, flag and enable
  // ----------------------------------------------------------------
  // Flag: hardware set wins over read or zero-write clear
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      prescale_select <= ptmr_pkg::PRE_RST;
      postscale_select <= ptmr_pkg::POST_RST;
      match_irq_flag <= 1'b0;
      match_irq_enable <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        prescale_select <= wdat[ptmr_pkg::PRE_LSB +: 2];
        postscale_select <= wdat[ptmr_pkg::POST_LSB +: 4];
      end
      if (post_wrap)
        match_irq_flag <= 1'b1;
      else if (rd_flag || (wr_flag && !wdat[ptmr_pkg::FLAG_BIT]))
        match_irq_flag <= 1'b0;
      if (wr_enable)
        match_irq_enable <= wdat[ptmr_pkg::ENABLE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Registered ack, data, match pulse and interrupt
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
      PERIOD_MATCH <= 1'b0;
      IRQ <= 1'b0;
    end
    else
    begin
      WB_ACK_O <= req;
      if (rd)
        WB_DAT_O <= {24'h000000, rd_byte};
      PERIOD_MATCH <= match_now;
      IRQ <= match_irq_flag && match_irq_enable;
    end
  end

  // ----------------------------------------------------------------
  // Check helper
  // ----------------------------------------------------------------
  // Matches counted since the postscaler last wrapped or was cleared
  logic [ptmr_pkg::SCL_W:0] match_seen;
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      match_seen <= '0;
    else if (scaler_clear || post_wrap)
      match_seen <= '0;
    else if (match_now)
      match_seen <= match_seen + 1'b1;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  a_tick_spacing: assert property (ins_tick |=> !ins_tick [*3])
    else $error("instruction tick closer than four clocks");
  a_count_step: assert property (count_step && !at_period
    |=> timer_count == $past(timer_count) + 8'h01)
    else $error("counter did not increment");
  a_fast_prescale: assert property (pre_step && pre_limit == 4'h0
    && !scaler_clear |-> pre_wrap)
    else $error("divide by one did not pass tick");
  a_match_equal: assert property (count_step && at_period
    |=> PERIOD_MATCH)
    else $error("match pulse missing on equality");
  a_match_clear: assert property (PERIOD_MATCH |-> timer_count == 8'h00)
    else $error("counter not cleared after match");
  a_match_single: assert property (PERIOD_MATCH |=> !PERIOD_MATCH [*3])
    else $error("match pulse longer than one clock");
  a_ctrl_keep: assert property (wr_ctrl |=> $stable(timer_count))
    else $error("control write disturbed counter");
  a_post_flag: assert property (post_wrap |=> match_irq_flag)
    else $error("postscaler wrap did not set flag");
  a_irq_gate: assert property (IRQ |-> $past(match_irq_flag && match_irq_enable))
    else $error("interrupt without flag and enable");
  a_sleep_hold: assert property (sleep_state && !wr_count && !wr_period
    |=> $stable(timer_count) && $stable(period_value))
    else $error("timer moved during sleep");
  a_flag_sticky: assert property (match_irq_flag && !rd_flag && !wr_flag
    |=> match_irq_flag)
    else $error("flag dropped without software clear");

  // Register access, interrupt line and sleep
  a_irq_level: assert property (match_irq_flag && match_irq_enable |=> IRQ)
    else $error("flag and enable set but no interrupt");
  a_flag_read: assert property (rd_flag && !post_wrap |=> !match_irq_flag)
    else $error("flag survived a read of its register");
  a_count_write: assert property (wr_count |=> timer_count == $past(wdat))
    else $error("counter write did not land");
  a_period_write: assert property (wr_period |=> period_value == $past(wdat))
    else $error("period write did not land");
  a_count_read: assert property (rd && hit_count
    |=> WB_DAT_O == {24'h000000, $past(timer_count)})
    else $error("counter read returned wrong value");
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("acknowledge longer than one clock");
  a_sleep_still: assert property (sleep_state |-> !pre_wrap)
    else $error("prescaler stepped during sleep");
  // Postscaler ratio against the helper count
  a_post_ratio: assert property (post_wrap |-> match_seen == {1'b0, postscale_select})
    else $error("postscaler wrapped at the wrong match count");

  c_match: cover property (PERIOD_MATCH);
  c_flag: cover property (post_wrap && postscale_select == 4'hF);
  c_sleep: cover property (sleep_state && ins_tick);
  c_irq: cover property (IRQ);
  c_slow_prescale: cover property (pre_wrap && prescale_select[1]);

endmodule // period_timer

//--- verif/test_period_timer.sv
// Self-checking bench of the period timer: register access, match timing,
// postscaler ratios, interrupt and sleep, against a small bench model.
// Assumes the rtl/ package and modules are compiled ahead of this file.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end

module test_period_timer;
  // ----------------------------------------------------------------
  // Signals and bench state
  // ----------------------------------------------------------------
  logic MCLK;
  logic RST_N;
  logic SLEEP;
  logic WB_CYC_I;
  logic WB_STB_I;
  logic WB_WE_I;
  logic [ptmr_pkg::ADR_W-1:0] WB_ADR_I;
  logic [3:0] WB_SEL_I;
  logic [31:0] WB_DAT_I;
  logic [31:0] WB_DAT_O;
  logic WB_ACK_O;
  logic PERIOD_MATCH;
  logic IRQ;
  int errors = 0; // Mismatches
  int cmp_count = 0; // Comparisons
  int cyc_n = 0; // Free cycle count
  int t_match [$]; // Cycle numbers of match pulses
  logic [31:0] seed = 32'h854AA653; // Xorshift state
  logic [7:0] exp_reg [0:4]; // Model: count, period, control, flag, enable
  logic [31:0] rd; // Last read data
  logic [7:0] p; // Period under test
  int m; // Match pulses seen
  int n; // Wait bound
  int post; // Postscale select

  period_timer uut (.MCLK(MCLK), .RST_N(RST_N), .SLEEP(SLEEP), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .PERIOD_MATCH(PERIOD_MATCH), .IRQ(IRQ));

  // Clock and cycle counter
  initial
  begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end
  always @(posedge MCLK) cyc_n <= cyc_n + 1;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic idle(input int k);
    repeat (k) @(posedge MCLK);
  endtask

  // One classic cycle, held until ack, then one idle cycle
  task automatic wb(input logic we, input logic [4:0] adr, input logic [7:0] wd,
    input logic [3:0] sel, output logic [31:0] rdat);
    int k;
    k = 0;
    @(posedge MCLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= adr;
    WB_SEL_I <= sel;
    WB_DAT_I <= {24'h000000, wd};
    do
    begin
      @(posedge MCLK);
      k++;
    end
    while (WB_ACK_O !== 1'b1 && k < 50);
    rdat = WB_DAT_O;
    if (k >= 50) errors++;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge MCLK);
  endtask

  // Write and keep the model in step; flag is not modelled here
  task automatic wr(input logic [4:0] adr, input logic [7:0] d);
    logic [31:0] dummy;
    wb(1'b1, adr, d, 4'hF, dummy);
    if (adr[1:0] == 2'h0 && adr[4:2] < 3'h5 && adr != ptmr_pkg::OFS_FLAG)
      exp_reg[adr[4:2]] = d;
  endtask

  task automatic rdchk(input string nm, input logic [4:0] adr, input logic [7:0] ex);
    wb(1'b0, adr, 8'h00, 4'hF, rd);
    `CHK(nm, {24'h000000, ex}, rd)
  endtask

  task automatic nap(input logic s);
    SLEEP <= s;
    idle(8);
  endtask

  task automatic wait_match();
    int k;
    k = 0;
    do
    begin
      @(posedge MCLK);
      k++;
    end
    while (PERIOD_MATCH !== 1'b1 && k < 3000);
    if (k >= 3000) errors++;
    t_match.push_back(cyc_n);
  endtask

  task automatic results();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog against a hung handshake or a missing pulse
  initial
  begin
    repeat (60000) @(posedge MCLK);
    errors++;
    results();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    RST_N = 1'b0;
    SLEEP = 1'b1;
    WB_CYC_I = 1'b0;
    WB_STB_I = 1'b0;
    WB_WE_I = 1'b0;
    WB_ADR_I = 5'h00;
    WB_SEL_I = 4'h0;
    WB_DAT_I = 32'h00000000;
    exp_reg = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
    idle(20);
    RST_N <= 1'b1;
    idle(8);
    // Reset values; sleep lands in the same cycle as the first instruction tick
    rdchk("count after reset", ptmr_pkg::OFS_COUNT, ptmr_pkg::COUNT_RST);
    for (int i = 1; i < 5; i++)
      rdchk("reset value", 5'(i * 4), exp_reg[i]);
    // Random register traffic while asleep; control write keeps count
    for (int k = 0; k < 3; k++)
    begin
      wr(ptmr_pkg::OFS_PERIOD, 8'(xs()));
      wr(ptmr_pkg::OFS_COUNT, 8'(xs()));
      wr(ptmr_pkg::OFS_CTRL, 8'(xs()) & 8'h7B);
      wr(ptmr_pkg::OFS_ENABLE, 8'(xs()) & 8'h01);
      for (int i = 0; i < 5; i++)
        rdchk("readback", 5'(i * 4), exp_reg[i]);
    end
    wb(1'b1, ptmr_pkg::OFS_PERIOD, 8'h12, 4'hE, rd);
    rdchk("masked byte write", ptmr_pkg::OFS_PERIOD, exp_reg[1]);
    wr(5'h14, 8'hA5);
    rdchk("unmapped", 5'h14, 8'h00);
    idle(100);
    rdchk("count held asleep", ptmr_pkg::OFS_COUNT, exp_reg[0]);
    rdchk("period held asleep", ptmr_pkg::OFS_PERIOD, exp_reg[1]);
    // Count rises by one each instruction tick at divide by one
    wr(ptmr_pkg::OFS_PERIOD, 8'hFF);
    wr(ptmr_pkg::OFS_CTRL, 8'h00);
    wr(ptmr_pkg::OFS_COUNT, 8'h00);
    nap(1'b0);
    idle(40);
    nap(1'b1);
    // Awake for 48 clocks between equal sleep delays: twelve ticks
    rdchk("count steps", ptmr_pkg::OFS_COUNT, 8'h0C);
    // Match interval for every prescale code
    wr(ptmr_pkg::OFS_ENABLE, 8'h00);
    for (int code = 0; code < 4; code++)
    begin
      p = 8'(xs() % 8);
      wr(ptmr_pkg::OFS_PERIOD, p);
      wr(ptmr_pkg::OFS_CTRL, 8'(code));
      wr(ptmr_pkg::OFS_COUNT, 8'h00);
      nap(1'b0);
      wait_match();
      wait_match();
      wait_match();
      `CHK("match interval", (p + 1) * (code == 0 ? 1 : code == 1 ? 4 : 16) * 4,
        t_match[$] - t_match[$-1])
      @(posedge MCLK);
      `CHK("match width", 1'b0, PERIOD_MATCH)
      if (code >= 2) rdchk("count after match", ptmr_pkg::OFS_COUNT, 8'h00);
      nap(1'b1);
    end
    // Postscaler ratios with the interrupt enabled
    wr(ptmr_pkg::OFS_PERIOD, 8'h02);
    wr(ptmr_pkg::OFS_ENABLE, 8'h01);
    for (int j = 0; j < 3; j++)
    begin
      post = (j == 0) ? 0 : (j == 1) ? int'(xs() % 15) + 1 : 15;
      wr(ptmr_pkg::OFS_CTRL, 8'(post << 3));
      wr(ptmr_pkg::OFS_COUNT, 8'h00);
      wb(1'b0, ptmr_pkg::OFS_FLAG, 8'h00, 4'hF, rd);
      SLEEP <= 1'b0;
      m = 0;
      n = 0;
      while (IRQ !== 1'b1 && n < 3000)
      begin
        @(posedge MCLK);
        n++;
        if (PERIOD_MATCH === 1'b1) m++;
      end
      `CHK("matches per flag", post + 1, m)
      nap(1'b1);
      rdchk("flag set", ptmr_pkg::OFS_FLAG, 8'h01);
      `CHK("irq after read", 1'b0, IRQ)
      rdchk("flag cleared", ptmr_pkg::OFS_FLAG, 8'h00);
    end
    // Masked flag raises no interrupt until enabled
    wr(ptmr_pkg::OFS_ENABLE, 8'h00);
    wr(ptmr_pkg::OFS_CTRL, 8'h00);
    SLEEP <= 1'b0;
    m = 0;
    repeat (200)
    begin
      @(posedge MCLK);
      if (IRQ !== 1'b0) m++;
    end
    nap(1'b1);
    `CHK("masked irq", 0, m)
    wr(ptmr_pkg::OFS_ENABLE, 8'h01);
    `CHK("irq on enable", 1'b1, IRQ)
    wr(ptmr_pkg::OFS_FLAG, 8'h01);
    `CHK("flag kept by one", 1'b1, IRQ)
    wr(ptmr_pkg::OFS_FLAG, 8'h00);
    `CHK("flag cleared by zero", 1'b0, IRQ)
    results();
  end
endmodule // test_period_timer
